// >>> src/bpc_breakpoint_ctrl.v
// breakpoint control registers with type decode and debug event generation
// assumes system-register and external-debug accesses and all context inputs arrive on clk
// address and context comparators sit outside; their per-breakpoint hits come in as vectors
`timescale 1ns/1ns
`include "bpc_breakpoint_defines.vh"

module bpc_breakpoint_ctrl #(
	parameter NUM_BP = 16,
	parameter CTX_AWARE_MASK = 16'hFFFF,
	parameter HAS_REALM = 1,
	parameter HAS_VHE = 1,
	parameter HAS_HYP = 1,
	parameter HAS_32BIT = 1
) (
	input wire clk,
	input wire rst_n,
	input wire sys_rd_en,
	input wire sys_wr_en,
	input wire [3:0] sys_index,
	input wire [63:0] sys_wdata,
	output reg [63:0] sys_rdata,
	output reg sys_rd_valid,
	output reg sys_undef,
	input wire ext_rd_en,
	input wire ext_wr_en,
	input wire [3:0] ext_index,
	input wire [31:0] ext_wdata,
	output reg [31:0] ext_rdata,
	output reg ext_rd_valid,
	output reg ext_undef,
	input wire [1:0] cur_el,
	input wire [1:0] cur_state,
	input wire host_extension_enable,
	input wire trap_general_exceptions,
	input wire [15:0] bp_enable,
	input wire [15:0] addr_hit,
	input wire pc_half,
	input wire [15:0] kernel_ctx_hit,
	input wire [15:0] host_ctx_hit,
	input wire [15:0] vm_id_hit,
	output reg [15:0] bp_event,
	output reg bp_event_any
);

// shared storage: the low 32 bits are the only ones that hold state
// words at or above NUM_BP are never written and never read out, so they
// keep their reset value and cost only area
reg [31:0] ctl_mem [0:`BPC_MAX_BP-1];

wire sys_impl;
wire ext_impl;
wire use_host_ctx;
wire [15:0] link_src;
wire [15:0] raw_event;
integer k;

// index range check against the implemented count
// index widened so the compare with the count runs at full width
assign sys_impl = ({28'h0000000, sys_index} < NUM_BP);
assign ext_impl = ({28'h0000000, ext_index} < NUM_BP);

// host context is compared under the host-extension conditions
// trap bit matters only at EL0; EL1 always uses the kernel context
assign use_host_ctx = (HAS_VHE != 0) & host_extension_enable &
	(((cur_el == `BPC_EL0) & trap_general_exceptions) | (cur_el == `BPC_EL2));

// store-side cleanup of a written word
// both views pass the same cleanup, so they read back alike
function [31:0] bpc_clean;
	input [31:0] w;
	reg [31:0] v;
	begin
		v = w & `BPC_WR_MASK;
		// extended security bit kept only with realm feature
		if (HAS_REALM != 0)
			v = v | (w & `BPC_SECURITY_STATE_CTRL_EXT_MASK);
		// without 32-bit execution the select field is all ones
		if (HAS_32BIT == 0)
			v[`BPC_HW_HI:`BPC_HW_LO] = `BPC_HW_WORD;
		bpc_clean = v;
	end
endfunction

// legal type codes for a breakpoint with the given context awareness
function bpc_type_ok;
	input [3:0] bt;
	input ctx_aware;
	begin
		case (bt)
			`BPC_T_ADDR, `BPC_T_ADDR_LNK: bpc_type_ok = 1'b1;
			// context types need a context-aware comparator
			`BPC_T_CTX, `BPC_T_CTX_LNK: bpc_type_ok = ctx_aware;
			// kernel-context types need the host extension
			`BPC_T_KCTX, `BPC_T_KCTX_LNK: bpc_type_ok = ctx_aware & (HAS_VHE != 0);
			// machine id types need the hypervisor level
			`BPC_T_VM, `BPC_T_VM_LNK, `BPC_T_VMCTX, `BPC_T_VMCTX_LNK:
				bpc_type_ok = ctx_aware & (HAS_HYP != 0);
			`BPC_T_HCTX, `BPC_T_HCTX_LNK, `BPC_T_FULL, `BPC_T_FULL_LNK:
				bpc_type_ok = ctx_aware & (HAS_VHE != 0);
			// codes 4 and 5 are reserved and never fire
			default: bpc_type_ok = 1'b0;
		endcase
	end
endfunction

// context comparison selected by type
function bpc_ctx_match;
	input [3:0] bt;
	input kctx;
	input hctx;
	input vm;
	input sel_host;
	begin
		case (bt)
			// context types follow the current regime
			`BPC_T_CTX, `BPC_T_CTX_LNK: bpc_ctx_match = sel_host ? hctx : kctx;
			`BPC_T_KCTX, `BPC_T_KCTX_LNK: bpc_ctx_match = kctx;
			`BPC_T_VM, `BPC_T_VM_LNK: bpc_ctx_match = vm;
			// kernel context and machine id together
			`BPC_T_VMCTX, `BPC_T_VMCTX_LNK: bpc_ctx_match = kctx & vm;
			`BPC_T_HCTX, `BPC_T_HCTX_LNK: bpc_ctx_match = hctx;
			`BPC_T_FULL, `BPC_T_FULL_LNK: bpc_ctx_match = kctx & hctx;
			default: bpc_ctx_match = 1'b0;
		endcase
	end
endfunction

// half-word qualifier for address types
// select field is read every cycle, so a rewrite acts from the next edge
function bpc_hw_ok;
	input [3:0] hw;
	input half;
	begin
		case (hw)
			// low half, high half or whole word
			`BPC_HW_LOW: bpc_hw_ok = ~half;
			`BPC_HW_HIGH: bpc_hw_ok = half;
			`BPC_HW_WORD: bpc_hw_ok = 1'b1;
			default: bpc_hw_ok = 1'b0;
		endcase
	end
endfunction

// a word changes at the edge that takes the write, so a read of the
// same index in that cycle still returns the old word
// both views write the same words; the system view wins a same-index collision
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		// a defined value, though software must not rely on it
		for (k = 0; k < `BPC_MAX_BP; k = k + 1)
			ctl_mem[k] <= `BPC_RESET_VAL;
	end else begin
		for (k = 0; k < `BPC_MAX_BP; k = k + 1) begin
			if (sys_wr_en && sys_impl && (sys_index == k[3:0])) begin
				ctl_mem[k] <= bpc_clean(sys_wdata[31:0]);
			end else if (ext_wr_en && ext_impl && (ext_index == k[3:0])) begin
				ctl_mem[k] <= bpc_clean(ext_wdata);
			end
		end
	end
end

// system register read and undefined response, one cycle after the request
// rdata is held between reads so a slow consumer may take it late
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		sys_rdata <= 64'h0000000000000000;
		sys_rd_valid <= 1'b0;
		sys_undef <= 1'b0;
	end else begin
		sys_rd_valid <= sys_rd_en & sys_impl;
		// unimplemented index raises undefined for read or write
		sys_undef <= (sys_rd_en | sys_wr_en) & ~sys_impl;
		if (sys_rd_en && sys_impl) begin
			sys_rdata <= {32'h00000000, ctl_mem[sys_index]};
		end
	end
end

// external debug view of the low 32 bits
// undefined is raised for writes as well as reads
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		ext_rdata <= 32'h00000000;
		ext_rd_valid <= 1'b0;
		ext_undef <= 1'b0;
	end else begin
		ext_rd_valid <= ext_rd_en & ext_impl;
		ext_undef <= (ext_rd_en | ext_wr_en) & ~ext_impl;
		if (ext_rd_en && ext_impl) begin
			// same storage as the system view
			ext_rdata <= ctl_mem[ext_index];
		end
	end
end

// per-breakpoint decode and qualification
// link lookup reads only link_src, which never depends on an address hit,
// so a breakpoint linked to itself or to an address type forms no loop
genvar gi;
generate
	for (gi = 0; gi < `BPC_MAX_BP; gi = gi + 1) begin : g_bp
		if (gi < NUM_BP) begin : g_impl
			wire [31:0] word;
			wire [3:0] bt;
			wire [3:0] li;
			wire [3:0] hw;
			wire valid;
			wire is_addr;
			wire ctx_hit;
			wire link_ok;
			wire addr_evt;
			wire ctx_evt;
			wire permit;

			assign word = ctl_mem[gi];
			assign bt = word[`BPC_TYPE_HI:`BPC_TYPE_LO];
			// link index, used only by the linked address type
			assign li = word[`BPC_LINK_HI:`BPC_LINK_LO];
			assign hw = word[`BPC_HW_HI:`BPC_HW_LO];
			assign valid = bpc_type_ok(bt, CTX_AWARE_MASK[gi]);
			assign is_addr = (bt == `BPC_T_ADDR) | (bt == `BPC_T_ADDR_LNK);
			assign ctx_hit = bpc_ctx_match(bt, kernel_ctx_hit[gi], host_ctx_hit[gi], vm_id_hit[gi],
				use_host_ctx);
			// linked context types only offer their match to an address breakpoint
			assign link_src[gi] = bp_enable[gi] & valid & ~is_addr & bt[0] & ctx_hit;
			// look up the breakpoint this one links to
			assign link_ok = link_src[li];
			// address match qualified by the half-word select
			assign addr_evt = is_addr & addr_hit[gi] & bpc_hw_ok(hw, pc_half) &
				((bt == `BPC_T_ADDR) | link_ok);
			// context types never look at the select field
			assign ctx_evt = ~is_addr & ~bt[0] & ctx_hit;

			// mode and state fields feed the filter
			bpc_perm_check #(
				.HAS_REALM(HAS_REALM)
			) u_perm (
				.higher_mode_ctrl(word[`BPC_HMC_BIT]),
				.security_state_ctrl(word[`BPC_SSC_HI:`BPC_SSC_LO]),
				.security_state_ctrl_ext(word[`BPC_SECURITY_STATE_CTRL_EXT_BIT]),
				.privilege_mode_ctrl(word[`BPC_PMC_HI:`BPC_PMC_LO]),
				.cur_el(cur_el),
				.cur_state(cur_state),
				.permit(permit)
			);

			assign raw_event[gi] = bp_enable[gi] & valid & (addr_evt | ctx_evt) & permit;
		end else begin : g_none
			assign link_src[gi] = 1'b0;
			assign raw_event[gi] = 1'b0;
		end
	end
endgenerate

// registered event outputs
// one cycle of latency keeps comparator glitches off the event lines
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		bp_event <= 16'h0000;
		bp_event_any <= 1'b0;
	end else begin
		bp_event <= raw_event;
		bp_event_any <= |raw_event;
	end
end

endmodule // bpc_breakpoint_ctrl

// >>> src/bpc_breakpoint_defines.vh
// field layout, type codes and context encodings for the breakpoint control block
// assumes a 32-bit stored view; bits 63:32 of the system view are always zero
`ifndef BPC_BREAKPOINT_DEFINES_VH
`define BPC_BREAKPOINT_DEFINES_VH

// register count and index width
`define BPC_MAX_BP 16
`define BPC_IDX_W 4

// field positions
`define BPC_SECURITY_STATE_CTRL_EXT_BIT 29
`define BPC_TYPE_HI 23
`define BPC_TYPE_LO 20
`define BPC_LINK_HI 19
`define BPC_LINK_LO 16
`define BPC_SSC_HI 15
`define BPC_SSC_LO 14
`define BPC_HMC_BIT 13
`define BPC_HW_HI 8
`define BPC_HW_LO 5
`define BPC_PMC_HI 2
`define BPC_PMC_LO 1

// writable bits without the extended security bit, and that bit alone
`define BPC_WR_MASK 32'h00FFE1E6
`define BPC_SECURITY_STATE_CTRL_EXT_MASK 32'h20000000
// stored value after reset
`define BPC_RESET_VAL 32'h00000000

// breakpoint type codes
`define BPC_T_ADDR 4'h0
`define BPC_T_ADDR_LNK 4'h1
`define BPC_T_CTX 4'h2
`define BPC_T_CTX_LNK 4'h3
`define BPC_T_KCTX 4'h6
`define BPC_T_KCTX_LNK 4'h7
`define BPC_T_VM 4'h8
`define BPC_T_VM_LNK 4'h9
`define BPC_T_VMCTX 4'hA
`define BPC_T_VMCTX_LNK 4'hB
`define BPC_T_HCTX 4'hC
`define BPC_T_HCTX_LNK 4'hD
`define BPC_T_FULL 4'hE
`define BPC_T_FULL_LNK 4'hF

// half-word select patterns
`define BPC_HW_LOW 4'h3
`define BPC_HW_HIGH 4'hC
`define BPC_HW_WORD 4'hF

// exception levels
`define BPC_EL0 2'h0
`define BPC_EL1 2'h1
`define BPC_EL2 2'h2
`define BPC_EL3 2'h3

// security states
`define BPC_ST_NONSEC 2'h0
`define BPC_ST_SECURE 2'h1
`define BPC_ST_REALM 2'h2
`define BPC_ST_ROOT 2'h3

// security-state control codes
`define BPC_SSC_ANY 2'h0
`define BPC_SSC_NONSEC 2'h1
`define BPC_SSC_SECURE 2'h2
`define BPC_SSC_BOTH 2'h3

`endif

// >>> src/bpc_perm_check.v
// privilege and security-state filter for one breakpoint
// assumes current level and security state come from the core on the same clock
`timescale 1ns/1ns
`include "bpc_breakpoint_defines.vh"

module bpc_perm_check #(
	parameter HAS_REALM = 1
) (
	input wire higher_mode_ctrl,
	input wire [1:0] security_state_ctrl,
	input wire security_state_ctrl_ext,
	input wire [1:0] privilege_mode_ctrl,
	input wire [1:0] cur_el,
	input wire [1:0] cur_state,
	output wire permit
);

reg el_ok;
reg state_ok;
wire ext;

assign ext = (HAS_REALM != 0) & security_state_ctrl_ext;

// level filter: pmc bit 1 for EL0, bit 0 for EL1, higher mode for EL2, higher mode with secure code and no extended bit for EL3
always @* begin
	case (cur_el)
		`BPC_EL0: el_ok = privilege_mode_ctrl[1];
		`BPC_EL1: el_ok = privilege_mode_ctrl[0];
		`BPC_EL2: el_ok = higher_mode_ctrl;
		`BPC_EL3: el_ok = higher_mode_ctrl & (security_state_ctrl == `BPC_SSC_SECURE) & ~ext;
		default: el_ok = 1'b0;
	endcase
end

// security-state filter; extended codes other than realm are reserved and never fire
always @* begin
	state_ok = 1'b0;
	if (ext) begin
		state_ok = (security_state_ctrl == `BPC_SSC_NONSEC) & (cur_state == `BPC_ST_REALM);
	end else begin
		case (security_state_ctrl)
			`BPC_SSC_ANY: state_ok = (cur_state != `BPC_ST_ROOT);
			`BPC_SSC_NONSEC: state_ok = (cur_state == `BPC_ST_NONSEC);
			`BPC_SSC_SECURE: state_ok = (cur_state == `BPC_ST_SECURE) |
				((cur_state == `BPC_ST_ROOT) & (cur_el == `BPC_EL3));
			`BPC_SSC_BOTH: state_ok = (cur_state == `BPC_ST_NONSEC) | (cur_state == `BPC_ST_SECURE);
			default: state_ok = 1'b0;
		endcase
	end
end

assign permit = el_ok & state_ok;

endmodule // bpc_perm_check

// >>> sim/bpc_checker.sv
// port checker for the breakpoint control block
// assumes one clock and an async active-low reset
`timescale 1ns/1ns
module bpc_checker #(
	parameter NUM_BP = 16
) (
	input wire clk,
	input wire rst_n,
	input wire sys_rd_en,
	input wire [3:0] sys_index,
	input wire [63:0] sys_rdata,
	input wire sys_rd_valid,
	input wire sys_undef,
	input wire ext_rd_en,
	input wire [3:0] ext_index,
	input wire ext_rd_valid,
	input wire ext_undef,
	input wire [15:0] bp_enable,
	input wire [15:0] bp_event,
	input wire bp_event_any
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_sys_undef: assert property (sys_rd_en && sys_index >= NUM_BP |=> sys_undef && !sys_rd_valid)
		else $error("sys undef missing");
	chk_sys_valid: assert property (sys_rd_en && sys_index < NUM_BP |=> sys_rd_valid && !sys_undef)
		else $error("sys valid missing");
	chk_ext_undef: assert property (ext_rd_en && ext_index >= NUM_BP |=> ext_undef && !ext_rd_valid)
		else $error("ext undef missing");
	chk_ext_valid: assert property (ext_rd_en && ext_index < NUM_BP |=> ext_rd_valid)
		else $error("ext valid missing");
	chk_valid_cause: assert property (sys_rd_valid |-> $past(sys_rd_en))
		else $error("sys valid unasked");
	chk_upper_zero: assert property (sys_rd_valid |-> sys_rdata[63:30] == 34'h0)
		else $error("upper bits set");
	chk_resv_zero: assert property (sys_rd_valid |-> sys_rdata[28:24] == 5'h00 && sys_rdata[12:9] == 4'h0)
		else $error("reserved bits set");
	chk_any_or: assert property (bp_event_any == (|bp_event))
		else $error("event summary wrong");
	chk_event_enable: assert property ((bp_event & ~$past(bp_enable)) == 16'h0000)
		else $error("event while disabled");
	cover property (sys_undef);
	cover property (bp_event_any);
	cover property (sys_rd_valid && sys_rdata[29]);
endmodule // bpc_checker

bind bpc_breakpoint_ctrl bpc_checker #(.NUM_BP(NUM_BP)) u_chk (.clk(clk), .rst_n(rst_n),
	.sys_rd_en(sys_rd_en), .sys_index(sys_index), .sys_rdata(sys_rdata), .sys_rd_valid(sys_rd_valid),
	.sys_undef(sys_undef), .ext_rd_en(ext_rd_en), .ext_index(ext_index), .ext_rd_valid(ext_rd_valid),
	.ext_undef(ext_undef), .bp_enable(bp_enable), .bp_event(bp_event), .bp_event_any(bp_event_any));

// >>> sim/bpc_core_model.sv
// core context model: level, state, enables and comparator hits
// assumes the bench changes the request between rising edges
`timescale 1ns/1ns
module bpc_core_model (
	input wire [86:0] ctx_req,
	output wire [1:0] cur_el,
	output wire [1:0] cur_state,
	output wire host_extension_enable,
	output wire trap_general_exceptions,
	output wire [15:0] bp_enable,
	output wire [15:0] addr_hit,
	output wire pc_half,
	output wire [15:0] kernel_ctx_hit,
	output wire [15:0] host_ctx_hit,
	output wire [15:0] vm_id_hit
);
	// context given as one consistent set
	assign {cur_el, cur_state, host_extension_enable, trap_general_exceptions, bp_enable, addr_hit, pc_half,
		kernel_ctx_hit, host_ctx_hit, vm_id_hit} = ctx_req;
endmodule // bpc_core_model

// >>> sim/tb_top.sv
// self-checking bench for the breakpoint control block
// assumes twelve breakpoints, stimulus on the falling edge
`timescale 1ns/1ns
module tb_top;
	localparam NBP = 12;
	logic clk = 0;
	logic rst_n = 0;
	logic sys_rd_en = 0, sys_wr_en = 0, ext_rd_en = 0, ext_wr_en = 0;
	logic [3:0] sys_index = 0, ext_index = 0;
	logic [63:0] sys_wdata = 0;
	logic [31:0] ext_wdata = 0;
	logic [86:0] ctx = 0;
	wire [63:0] sys_rdata;
	wire [31:0] ext_rdata;
	wire sys_rd_valid, sys_undef, ext_rd_valid, ext_undef, bp_event_any, pc_half, hx, tge;
	wire [1:0] cur_el, cur_state;
	wire [15:0] bp_enable, addr_hit, kh, hh, vh, bp_event;
	int bad_count = 0, samples_checked = 0, cycles = 0;

	// 20 MHz clock
	always #25 clk = ~clk;

	bpc_core_model u_core (.ctx_req(ctx), .cur_el(cur_el), .cur_state(cur_state), .host_extension_enable(hx),
		.trap_general_exceptions(tge), .bp_enable(bp_enable), .addr_hit(addr_hit), .pc_half(pc_half),
		.kernel_ctx_hit(kh), .host_ctx_hit(hh), .vm_id_hit(vh));

	bpc_breakpoint_ctrl #(.NUM_BP(NBP)) u_dut (.clk(clk), .rst_n(rst_n), .sys_rd_en(sys_rd_en),
		.sys_wr_en(sys_wr_en), .sys_index(sys_index), .sys_wdata(sys_wdata), .sys_rdata(sys_rdata),
		.sys_rd_valid(sys_rd_valid), .sys_undef(sys_undef), .ext_rd_en(ext_rd_en), .ext_wr_en(ext_wr_en),
		.ext_index(ext_index), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .ext_rd_valid(ext_rd_valid),
		.ext_undef(ext_undef), .cur_el(cur_el), .cur_state(cur_state), .host_extension_enable(hx),
		.trap_general_exceptions(tge), .bp_enable(bp_enable), .addr_hit(addr_hit), .pc_half(pc_half),
		.kernel_ctx_hit(kh), .host_ctx_hit(hh), .vm_id_hit(vh), .bp_event(bp_event), .bp_event_any(bp_event_any));

	task cmp_reg(input string n, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task cmp_ev(input logic [15:0] e);
		samples_checked++;
		if (bp_event !== e) begin
			bad_count++;
			$display("mismatch bp_event expected %h seen %h", e, bp_event);
		end
	endtask

	// one access on either view, entered and left at a falling edge
	task acc(input bit x, input bit wr, input logic [3:0] i, input logic [63:0] d, input bit ud);
		if (x) begin
			ext_index = i;
			ext_wdata = d[31:0];
			ext_wr_en = wr;
			ext_rd_en = !wr;
		end else begin
			sys_index = i;
			sys_wdata = d;
			sys_wr_en = wr;
			sys_rd_en = !wr;
		end
		@(negedge clk);
		{sys_wr_en, sys_rd_en, ext_wr_en, ext_rd_en} = 4'h0;
		cmp_reg("undef", ud, x ? ext_undef : sys_undef);
		if (!wr) cmp_reg("valid", !ud, x ? ext_rd_valid : sys_rd_valid);
		if (!wr && !ud) cmp_reg("rdata", d, x ? {32'h0, ext_rdata} : sys_rdata);
		// idle edge so the next call never re-raises a strobe in this step
		@(negedge clk);
	endtask

	// present a context, then look at the registered events
	task ev(input logic [1:0] el, input logic [1:0] ht, input logic [15:0] en, input logic [15:0] ah,
		input logic [15:0] k, input logic [15:0] h, input logic [15:0] v, input bit half, input logic [15:0] e);
		ctx = {el, 2'h0, ht, en, ah, half, k, h, v};
		@(posedge clk);
		@(negedge clk);
		cmp_ev(e);
		cmp_reg("any", |e, bp_event_any);
	endtask

	task stop_test;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			stop_test;
		end
	end

	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1;
		@(negedge clk);
		acc(0, 1, 4'h3, 64'hFFFFFFFFFFFFFFFF, 0);
		acc(0, 0, 4'h3, 64'h20FFE1E6, 0);
		acc(1, 0, 4'h3, 64'h20FFE1E6, 0);
		acc(1, 1, 4'h4, 64'h12345678, 0);
		acc(0, 0, 4'h4, 64'h00344060, 0);
		acc(0, 0, 4'hB, 64'h0, 0);
		acc(0, 1, 4'hC, 64'h1E2, 1);
		acc(0, 0, 4'hC, 64'h0, 1);
		acc(1, 0, 4'hF, 64'h0, 1);
		// breakpoint setups, legal half-word patterns except on indices 3, 4, 9, 10 and 11
		acc(0, 1, 4'h0, 64'h1E2, 0);
		acc(0, 1, 4'h1, 64'h1201E2, 0);
		acc(0, 1, 4'h2, 64'h3001E2, 0);
		acc(0, 1, 4'h5, 64'h2001E4, 0);
		acc(0, 1, 4'h6, 64'h8001E2, 0);
		acc(0, 1, 4'h7, 64'h62, 0);
		acc(0, 1, 4'h8, 64'h182, 0);
		acc(0, 1, 4'h3, 64'h600002, 0);
		acc(0, 1, 4'h4, 64'h400002, 0);
		acc(0, 1, 4'h9, 64'hA00002, 0);
		acc(0, 1, 4'hA, 64'hC02000, 0);
		acc(0, 1, 4'hB, 64'hE00002, 0);
		ev(1, 0, 16'h0001, 16'h0001, 0, 0, 0, 0, 16'h0001);
		ev(1, 0, 16'h0000, 16'h0001, 0, 0, 0, 0, 16'h0000);
		ev(0, 0, 16'h0001, 16'h0001, 0, 0, 0, 0, 16'h0000);
		ev(1, 0, 16'h0006, 16'h0002, 16'h0004, 0, 0, 0, 16'h0002);
		ev(1, 0, 16'h0006, 16'h0002, 0, 0, 0, 0, 16'h0000);
		ev(0, 3, 16'h0020, 0, 0, 16'h0020, 0, 0, 16'h0020);
		ev(0, 3, 16'h0020, 0, 16'h0020, 0, 0, 0, 16'h0000);
		ev(0, 0, 16'h0020, 0, 16'h0020, 0, 0, 0, 16'h0020);
		ev(1, 0, 16'h0040, 0, 0, 0, 16'h0040, 0, 16'h0040);
		ev(1, 0, 16'h0180, 16'h0180, 0, 0, 0, 0, 16'h0080);
		ev(1, 0, 16'h0180, 16'h0180, 0, 0, 0, 1, 16'h0100);
		ev(1, 0, 16'h0018, 0, 16'h0018, 16'h0018, 16'h0018, 0, 16'h0008);
		ev(1, 0, 16'h0200, 0, 16'h0200, 0, 16'h0200, 0, 16'h0200);
		ev(1, 0, 16'h0200, 0, 16'h0200, 0, 0, 0, 16'h0000);
		ev(2, 0, 16'h0400, 0, 0, 16'h0400, 0, 0, 16'h0400);
		ev(1, 0, 16'h0400, 0, 0, 16'h0400, 0, 0, 16'h0000);
		ev(1, 0, 16'h0800, 0, 16'h0800, 16'h0800, 0, 0, 16'h0800);
		ev(1, 0, 16'h0800, 0, 0, 16'h0800, 0, 0, 16'h0000);
		stop_test;
	end
endmodule // tb_top
